// ===== core/ssy_synth.sv
// sine/cosine synthesizer: phase accumulators, offset adder, lookup, output FIFO
// assumes all inputs come from logic on clock_i; programming port is a plain strobe
`timescale 1ns/1ps

module ssy_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             reset_i,
    input  wire logic             clear_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign out_data_o  = mem_r[rd_ptr_r];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i || clear_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // a count past the depth would mean a push overwrote a word not yet read
    fifo_bound_a: assert property (@(posedge clock_i) disable iff (reset_i)
        count_r <= (AW+1)'(DEPTH))
        else $error("fifo count beyond depth");
    fifo_clear_a: assert property (@(posedge clock_i) disable iff (reset_i)
        clear_i |=> count_r == '0)
        else $error("fifo not emptied by clear");
endmodule : ssy_fifo

module ssy_synth (
    // clock, reset and optional controls
    input  wire logic                        clock_i,
    input  wire logic                        reset_i,
    input  wire logic                        clk_en_i,
    input  wire logic                        sync_clear_input_i,
    // programming port
    input  wire logic                        prog_we_i,
    input  wire logic [ssy_pkg::CHAN_W-1:0]  prog_addr_i,
    input  wire logic                        prog_sel_i,
    input  wire logic [ssy_pkg::PHASE_W-1:0] prog_data_i,
    // streamed values
    input  wire logic [ssy_pkg::PHASE_W-1:0] increment_stream_input_i,
    input  wire logic [ssy_pkg::PHASE_W-1:0] offset_stream_input_i,
    // sample outputs
    input  wire logic                        out_ready_i,
    output logic [ssy_pkg::OUT_W-1:0]        sine_o,
    output logic [ssy_pkg::OUT_W-1:0]        cosine_o,
    output logic [ssy_pkg::PHASE_W-1:0]      phase_o,
    output logic [ssy_pkg::CHAN_W-1:0]       channel_o,
    output logic                             out_valid_o,
    output logic                             accept_ready_flag_o
);
    localparam int PW  = ssy_pkg::PHASE_W;
    localparam int OW  = ssy_pkg::OUT_W;
    localparam int CW  = ssy_pkg::CHAN_W;
    localparam int FW  = 2*OW + PW + CW;
    localparam int QHI = PW - 1;
    localparam int ILO = PW - 2 - ssy_pkg::QTR_W;

    // ------------------------------------------------------------
    // lookup helpers
    // ------------------------------------------------------------
    function automatic logic [OW-1:0] wave(input logic [1:0] quad, input logic [3:0] idx);
        logic [3:0]    pos;
        logic [OW-1:0] mag;
        pos = quad[0] ? ~idx : idx;
        mag = ssy_pkg::UNIT_CIRCLE ? OW'(ssy_pkg::UNIT_TAB[pos]) : OW'(ssy_pkg::FULL_TAB[pos]);
        return quad[1] ? -mag : mag;
    endfunction : wave

    function automatic logic [OW-1:0] sine_of(input logic [PW-1:0] ph);
        logic [OW-1:0] s;
        s = wave(ph[QHI-:2], ph[ILO+:4]);
        return ssy_pkg::NEG_SINE ? -s : s;
    endfunction : sine_of

    function automatic logic [OW-1:0] cosine_of(input logic [PW-1:0] ph);
        logic [OW-1:0] c;
        c = wave(ph[QHI-:2] + 2'h1, ph[ILO+:4]);
        return ssy_pkg::NEG_COSINE ? -c : c;
    endfunction : cosine_of

    // ------------------------------------------------------------
    // per-channel state
    // ------------------------------------------------------------
    logic [PW-1:0] acc_r                 [ssy_pkg::CHANNELS];
    logic [PW-1:0] phase_increment_value_r [ssy_pkg::CHANNELS];
    logic [PW-1:0] phase_offset_value_r    [ssy_pkg::CHANNELS];
    logic [CW-1:0] chan_r;
    logic [PW-1:0] inc_sel;
    logic [PW-1:0] off_sel;
    logic [PW-1:0] acc_cur;
    logic [PW-1:0] acc_nxt;
    logic          advance;
    logic          fifo_in_ready;

    // stalls when clk_en_i is low or when a finished sample cannot enter the FIFO
    logic [PW-1:0] phase1_r;
    logic [CW-1:0] chan1_r;
    logic          v1_r;
    logic [PW-1:0] phase2_r;
    logic [CW-1:0] chan2_r;
    logic [OW-1:0] sin2_r;
    logic [OW-1:0] cos2_r;
    logic          v2_r;

    assign advance = clk_en_i & (~v2_r | fifo_in_ready);
    assign acc_cur = acc_r[chan_r];

    always_comb begin
        unique case (ssy_pkg::INC_MODE)
            ssy_pkg::SSY_SRC_FIXED:  inc_sel = ssy_pkg::FIXED_INC;
            ssy_pkg::SSY_SRC_STREAM: inc_sel = increment_stream_input_i;
            default:                 inc_sel = phase_increment_value_r[chan_r];
        endcase
    end

    always_comb begin
        unique case (ssy_pkg::OFF_MODE)
            ssy_pkg::SSY_SRC_FIXED:  off_sel = ssy_pkg::FIXED_OFF;
            ssy_pkg::SSY_SRC_PROG:   off_sel = phase_offset_value_r[chan_r];
            ssy_pkg::SSY_SRC_STREAM: off_sel = offset_stream_input_i;
            default:                 off_sel = '0;
        endcase
    end

    assign acc_nxt = acc_cur + inc_sel;

    for (genvar g = 0; g < ssy_pkg::CHANNELS; g++) begin : g_chan
        always_ff @(posedge clock_i) begin
            if (reset_i || sync_clear_input_i) begin
                acc_r[g] <= '0;
            end else if (advance && chan_r == CW'(g)) begin
                acc_r[g] <= acc_nxt;
            end
        end

        // offset registers fold away unless OFF_MODE is SSY_SRC_PROG; increment registers only under SSY_SRC_FIXED or SSY_SRC_STREAM
        always_ff @(posedge clock_i) begin
            if (reset_i) begin
                phase_increment_value_r[g] <= ssy_pkg::INIT_INC;
                phase_offset_value_r[g]    <= ssy_pkg::INIT_OFF;
            end else if (prog_we_i && prog_addr_i == CW'(g)) begin
                if (prog_sel_i == ssy_pkg::SEL_INC) begin
                    phase_increment_value_r[g] <= prog_data_i;
                end else begin
                    phase_offset_value_r[g] <= prog_data_i;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // channel sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (reset_i || sync_clear_input_i) begin
            chan_r <= '0;
        end else if (advance) begin
            chan_r <= (chan_r == CW'(ssy_pkg::CHANNELS-1)) ? '0 : chan_r + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // offset stage and lookup stage
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (advance) begin
            phase1_r <= acc_cur + off_sel;
            chan1_r  <= chan_r;
            phase2_r <= phase1_r;
            chan2_r  <= chan1_r;
            sin2_r   <= sine_of(phase1_r);
            cos2_r   <= cosine_of(phase1_r);
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i || sync_clear_input_i) begin
            v1_r <= 1'b0;
            v2_r <= 1'b0;
        end else if (advance) begin
            v1_r <= 1'b1;
            v2_r <= v1_r;
        end
    end

    // ------------------------------------------------------------
    // output FIFO and output register
    // ------------------------------------------------------------
    logic          fifo_out_valid;
    logic [FW-1:0] fifo_out_data;
    logic          take;

    assign take = fifo_out_valid & (~out_valid_o | out_ready_i);

    ssy_fifo #(
        .WIDTH (FW),
        .DEPTH (ssy_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .reset_i     (reset_i),
        .clear_i     (sync_clear_input_i),
        .in_valid_i  (v2_r & clk_en_i),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   ({sin2_r, cos2_r, phase2_r, chan2_r}),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (take),
        .out_data_o  (fifo_out_data)
    );

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sine_o    <= '0;
            cosine_o  <= '0;
            phase_o   <= '0;
            channel_o <= '0;
        end else if (take) begin
            sine_o    <= (ssy_pkg::OUT_SEL == ssy_pkg::SSY_OUT_COS) ? '0 : fifo_out_data[FW-1-:OW];
            cosine_o  <= (ssy_pkg::OUT_SEL == ssy_pkg::SSY_OUT_SIN) ? '0 : fifo_out_data[FW-1-OW-:OW];
            phase_o   <= fifo_out_data[CW+:PW];
            channel_o <= fifo_out_data[CW-1:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i || sync_clear_input_i) begin
            out_valid_o <= 1'b0;
        end else if (take) begin
            out_valid_o <= 1'b1;
        end else if (out_ready_i) begin
            out_valid_o <= 1'b0;
        end
    end

    // input side never refuses a sample; stalls come only from the output FIFO or a low clk_en_i
    always_ff @(posedge clock_i) begin
        accept_ready_flag_o <= 1'b1;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    sequence s_lookup;
        advance && v1_r && !sync_clear_input_i;
    endsequence

    // one held sample replaced by the next; a clear breaks the chain
    sequence s_out_step;
        take && out_valid_o && out_ready_i && !sync_clear_input_i;
    endsequence

    cfg_taylor_width_a: assert property (!ssy_pkg::TAYLOR || PW >= ssy_pkg::TAYLOR_MIN_PW)
        else $error("taylor build with too narrow a phase");
    cfg_taylor_sfdr_a: assert property (!ssy_pkg::TAYLOR || ssy_pkg::SFDR_X10 > ssy_pkg::TAYLOR_SFDR_X10)
        else $error("taylor build at too low a target");
    cfg_out_width_a: assert property (OW >= ssy_pkg::MIN_OUT_W)
        else $error("output width below target minimum");
    cfg_latency_a: assert property (ssy_pkg::PIPE_LATENCY >= ssy_pkg::MIN_LATENCY)
        else $error("latency below minimum");
    fixed_inc_a: assert property (ssy_pkg::INC_MODE != ssy_pkg::SSY_SRC_FIXED || inc_sel == ssy_pkg::FIXED_INC)
        else $error("fixed increment changed");
    inc_store_a: assert property (prog_we_i && prog_sel_i == ssy_pkg::SEL_INC
        |=> phase_increment_value_r[$past(prog_addr_i)] == $past(prog_data_i))
        else $error("programmed increment not stored");
    accum_step_a: assert property (advance && !sync_clear_input_i
        |=> acc_r[$past(chan_r)] == $past(acc_nxt) && phase1_r == $past(acc_cur) + $past(off_sel))
        else $error("accumulator step wrong");
    phase_align_a: assert property (s_lookup
        |=> phase2_r == $past(phase1_r) && sin2_r == sine_of(phase2_r) && cos2_r == cosine_of(phase2_r))
        else $error("phase not aligned with samples");
    unit_peak_a: assert property (ssy_pkg::UNIT_CIRCLE && v2_r
        |-> ($signed(sin2_r) <= $signed(ssy_pkg::UNIT_HALF) && $signed(sin2_r) >= -$signed(ssy_pkg::UNIT_HALF)))
        else $error("unit circle sample beyond one half");
    clear_state_a: assert property (sync_clear_input_i |=> chan_r == '0 && !v1_r && !v2_r && !out_valid_o)
        else $error("clear left state behind");
    chan_seq_a: assert property (advance && !sync_clear_input_i
        |=> chan_r == (($past(chan_r) == CW'(ssy_pkg::CHANNELS-1)) ? '0 : $past(chan_r) + 1'b1))
        else $error("channel sequence broken");
    ready_high_a: assert property (##1 accept_ready_flag_o)
        else $error("ready-for-data dropped");
    valid_hold_a: assert property (out_valid_o && !out_ready_i && !sync_clear_input_i
        |=> out_valid_o && $stable(sine_o) && $stable(channel_o))
        else $error("held sample changed");
    off_store_a: assert property (prog_we_i && prog_sel_i == ssy_pkg::SEL_OFF
        |=> phase_offset_value_r[$past(prog_addr_i)] == $past(prog_data_i))
        else $error("programmed offset not stored");
    out_order_a: assert property (s_out_step
        |=> channel_o == (($past(channel_o) == CW'(ssy_pkg::CHANNELS-1)) ? '0 : $past(channel_o) + 1'b1))
        else $error("output channel out of order");
    // the phase that leaves with a sample must still look up to that very sample
    out_pair_a: assert property (out_valid_o && ssy_pkg::OUT_SEL != ssy_pkg::SSY_OUT_COS
        |-> sine_o == sine_of(phase_o))
        else $error("sine not paired with its phase");
    cos_pair_a: assert property (out_valid_o && ssy_pkg::OUT_SEL != ssy_pkg::SSY_OUT_SIN
        |-> cosine_o == cosine_of(phase_o))
        else $error("cosine not paired with its phase");
    out_select_a: assert property (out_valid_o
        |-> (ssy_pkg::OUT_SEL != ssy_pkg::SSY_OUT_COS || sine_o == '0)
            && (ssy_pkg::OUT_SEL != ssy_pkg::SSY_OUT_SIN || cosine_o == '0))
        else $error("unselected output not held at zero");
    enable_hold_a: assert property (!clk_en_i && !sync_clear_input_i
        |=> $stable(chan_r) && $stable(v2_r) && $stable(acc_cur))
        else $error("pipeline moved without clock enable");
endmodule : ssy_synth

// ===== include/ssy_pkg.sv
// sine/cosine synthesizer: build constants, modes and quarter-wave tables
// assumes one 100 MHz clock; every option here is fixed at build time
package ssy_pkg;

    // ------------------------------------------------------------
    // widths and channel count
    // ------------------------------------------------------------
    localparam int PHASE_W    = 16;
    localparam int OUT_W      = 6;
    localparam int CHANNELS   = 4;
    localparam int CHAN_W     = 2;
    localparam int FIFO_DEPTH = 8;
    localparam int QTR_W      = 4;
    localparam int MAG_W      = OUT_W - 1;

    // ------------------------------------------------------------
    // value sources and output selection
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SSY_SRC_NONE   = 2'h0,
        SSY_SRC_FIXED  = 2'h1,
        SSY_SRC_PROG   = 2'h3,
        SSY_SRC_STREAM = 2'h2
    } ssy_src_e;

    typedef enum logic [1:0] {
        SSY_OUT_SIN  = 2'h1,
        SSY_OUT_COS  = 2'h2,
        SSY_OUT_BOTH = 2'h3
    } ssy_outsel_e;

    localparam ssy_src_e    INC_MODE = SSY_SRC_PROG;
    localparam ssy_src_e    OFF_MODE = SSY_SRC_PROG;
    localparam ssy_outsel_e OUT_SEL  = SSY_OUT_BOTH;
    localparam logic NEG_SINE        = 1'h0;
    localparam logic NEG_COSINE      = 1'h0;
    localparam logic UNIT_CIRCLE     = 1'h0;
    localparam logic TAYLOR          = 1'h0;
    localparam logic BLOCK_ROM       = 1'h0;
    localparam logic TAYLOR2_BROM    = 1'h0;

    // ------------------------------------------------------------
    // derived limits (dB in tenths)
    // ------------------------------------------------------------
    localparam int SFDR_X10         = 360;
    localparam int TAYLOR_SFDR_X10  = 660;
    localparam int DB_PER_BIT_X10   = 60;
    localparam int TAYLOR_MIN_PW    = 12;
    localparam int MIN_OUT_W        = (SFDR_X10 + DB_PER_BIT_X10 - 1) / DB_PER_BIT_X10 + int'(TAYLOR);
    localparam int PIPE_LATENCY     = 2;
    localparam int MIN_LATENCY      = 1 + int'(INC_MODE == SSY_SRC_STREAM) + int'(BLOCK_ROM) + int'(TAYLOR2_BROM);

    // ------------------------------------------------------------
    // constant and initial values
    // ------------------------------------------------------------
    localparam logic [PHASE_W-1:0] FIXED_INC = 16'h0400;
    localparam logic [PHASE_W-1:0] FIXED_OFF = 16'h0000;
    localparam logic [PHASE_W-1:0] INIT_INC  = 16'h0000;
    localparam logic [PHASE_W-1:0] INIT_OFF  = 16'h0000;
    localparam logic SEL_INC = 1'h0;
    localparam logic SEL_OFF = 1'h1;

    // quarter-wave magnitudes, entry 15 first; unit table peaks at exactly one half
    localparam logic [15:0][MAG_W-1:0] FULL_TAB = {
        5'h1f, 5'h1f, 5'h1e, 5'h1d, 5'h1c, 5'h1b, 5'h19, 5'h17,
        5'h15, 5'h12, 5'h10, 5'h0d, 5'h0a, 5'h08, 5'h05, 5'h02};
    localparam logic [15:0][MAG_W-1:0] UNIT_TAB = {
        5'h10, 5'h10, 5'h10, 5'h0f, 5'h0e, 5'h0e, 5'h0d, 5'h0c,
        5'h0b, 5'h0a, 5'h08, 5'h07, 5'h05, 5'h04, 5'h02, 5'h01};
    localparam logic [OUT_W-1:0] UNIT_HALF = 6'h10;

endpackage : ssy_pkg

// ===== verif/ssy_sink_model.sv
// downstream mixer model: takes samples from the synthesizer output handshake
// assumes the bench drives stall_i from clock_i; accepted samples are kept in got
`timescale 1ns/1ps

module ssy_sink_model (
    // clock and reset
    input  wire logic                        clock_i,
    input  wire logic                        reset_i,
    // stall command from the bench
    input  wire logic                        stall_i,
    // sample side
    input  wire logic                        valid_i,
    input  wire logic [ssy_pkg::OUT_W-1:0]   sine_i,
    input  wire logic [ssy_pkg::OUT_W-1:0]   cosine_i,
    input  wire logic [ssy_pkg::PHASE_W-1:0] phase_i,
    input  wire logic [ssy_pkg::CHAN_W-1:0]  channel_i,
    output logic                             ready_o
);
    // channel, phase, sine, cosine of each accepted sample
    logic [29:0] got[$];

    // a slow mixer simply withholds ready; it never drops a sample it accepted
    assign ready_o = !stall_i;

    always @(posedge clock_i) begin
        if (!reset_i && valid_i === 1'b1 && ready_o) begin
            got.push_back({channel_i, phase_i, sine_i, cosine_i});
        end
    end
endmodule : ssy_sink_model

// ===== verif/tb_ssy_synth.sv
// self-checking bench for ssy_synth: programming writes, stalled and enabled runs
// assumes the build constants of ssy_pkg: four channels, programmable increment and offset
`timescale 1ns/1ps

module tb_ssy_synth;
    logic        clock_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        clk_en_i = 1'b0;
    logic        sync_clear_input_i = 1'b0;
    logic        prog_we_i = 1'b0;
    logic [1:0]  prog_addr_i = 2'h0;
    logic        prog_sel_i = 1'b0;
    logic [15:0] prog_data_i = 16'h0000;
    logic        stall = 1'b1;
    logic        out_ready_i;
    logic [5:0]  sine_o;
    logic [5:0]  cosine_o;
    logic [15:0] phase_o;
    logic [1:0]  channel_o;
    logic        out_valid_o;
    logic        accept_ready_flag_o;
    int          num_errors = 0;
    int          n_tests = 0;
    logic [15:0] inc[4];
    logic [15:0] off[4];
    logic [18:0] wq[$];

    always #5 clock_i = ~clock_i;

    ssy_synth i_dut (.clock_i(clock_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
        .sync_clear_input_i(sync_clear_input_i), .prog_we_i(prog_we_i), .prog_addr_i(prog_addr_i),
        .prog_sel_i(prog_sel_i), .prog_data_i(prog_data_i), .increment_stream_input_i(16'h0000),
        .offset_stream_input_i(16'h0000), .out_ready_i(out_ready_i), .sine_o(sine_o),
        .cosine_o(cosine_o), .phase_o(phase_o), .channel_o(channel_o), .out_valid_o(out_valid_o),
        .accept_ready_flag_o(accept_ready_flag_o));

    ssy_sink_model i_sink (.clock_i(clock_i), .reset_i(reset_i), .stall_i(stall),
        .valid_i(out_valid_o), .sine_i(sine_o), .cosine_i(cosine_o), .phase_i(phase_o),
        .channel_i(channel_o), .ready_o(out_ready_i));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task stop_test();
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    // queued writes go out back to back, one per edge, then the strobe drops
    task write_all();
        while (wq.size() > 0) begin
            @(posedge clock_i);
            {prog_addr_i, prog_sel_i, prog_data_i} <= wq[0];
            prog_we_i <= 1'b1;
            if (wq[0][16] == ssy_pkg::SEL_INC) inc[wq[0][18:17]] = wq[0][15:0];
            else off[wq[0][18:17]] = wq[0][15:0];
            void'(wq.pop_front());
        end
        @(posedge clock_i);
        prog_we_i <= 1'b0;
    endtask : write_all

    // enable gaps and mixer stalls; a long stall fills the fifo and holds the outputs
    task run(input int n);
        logic [29:0] hold;
        for (int i = 0; i < n; i++) begin
            @(posedge clock_i);
            clk_en_i <= (i % 9) != 4;
            stall <= (i >= 100 && i < 140) || (i % 13 == 5);
            if (i == 130) hold = {channel_o, phase_o, sine_o, cosine_o};
            if (i == 136) check(32'({channel_o, phase_o, sine_o, cosine_o}), 32'(hold));
            if (i == 136) check(32'(out_valid_o), 32'h1);
            check(32'(accept_ready_flag_o), 32'h1);
        end
        @(posedge clock_i);
        clk_en_i <= 1'b0;
        stall <= 1'b0;
        repeat (30) @(posedge clock_i);
        check(32'(out_valid_o), 32'h0);
    endtask : run

    // replays each channel's accumulator and checks lookup symmetry by phase
    task verify(input int n_min);
        int k[4];
        logic [5:0] sin_of[int];
        logic [5:0] cos_of[int];
        logic [29:0] s;
        logic [15:0] ep;
        int pk;
        int ph;
        k = '{0, 0, 0, 0};
        pk = 0;
        check(32'(i_sink.got.size() >= n_min), 32'h1);
        for (int i = 0; i < i_sink.got.size(); i++) begin
            s = i_sink.got[i];
            check(32'(s[29:28]), 32'(i % 4));
            ep = 16'(k[s[29:28]] * int'(inc[s[29:28]]) + int'(off[s[29:28]]));
            check(32'(s[27:12]), 32'(ep));
            k[s[29:28]]++;
            sin_of[int'(s[27:12])] = s[11:6];
            cos_of[int'(s[27:12])] = s[5:0];
            if (!s[11] && int'(s[11:6]) > pk) pk = int'(s[11:6]);
        end
        foreach (sin_of[p]) begin
            if (sin_of.exists(p ^ 32'h8000)) check(32'(sin_of[p]), 32'(6'(-sin_of[p ^ 32'h8000])));
            ph = int'((p + 32'h4000) % 32'h1_0000);
            if (sin_of.exists(ph)) check(32'(cos_of[p]), 32'(sin_of[ph]));
        end
        check(32'(pk), 32'h1f);
    endtask : verify

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (11) @(posedge clock_i);
        check(32'(accept_ready_flag_o), 32'h1);
        check(32'(out_valid_o), 32'h0);
        @(posedge clock_i);
        reset_i <= 1'b0;
        wq = '{{2'h0, 1'b0, 16'h0400}, {2'h0, 1'b1, 16'h0000}, {2'h1, 1'b0, 16'h0123},
               {2'h1, 1'b1, 16'h4000}, {2'h2, 1'b0, 16'hfc00}, {2'h2, 1'b1, 16'h8000},
               {2'h3, 1'b0, 16'h0000}, {2'h3, 1'b1, 16'h1234}};
        write_all();
        run(360);
        verify(256);
        @(posedge clock_i);
        stall <= 1'b1;
        sync_clear_input_i <= 1'b1;
        @(posedge clock_i);
        sync_clear_input_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        check(32'(out_valid_o), 32'h0);
        i_sink.got.delete();
        wq = '{{2'h1, 1'b0, 16'h0800}, {2'h3, 1'b1, 16'hc000}};
        write_all();
        run(240);
        verify(150);
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clock_i);
        num_errors++;
        stop_test();
    end
endmodule : tb_ssy_synth
